// File: pkg/bbse_pkg.sv
// Purpose: constants for the relative jump and single bit force executor
// Assumes: 16-bit instruction words, 21-bit byte program counter
// Notes:   quarter phases are one-hot codes of one mclk each
package bbse_pkg;
    localparam int          PC_W         = 21;
    localparam int          ADDR_W       = 12;
    localparam logic [4:0]  JUMP_OPCODE  = 5'h1a;  // 1101 then 0
    localparam logic [3:0]  BSET_OPCODE  = 4'h8;   // 1000
    localparam int          OP_JUMP_HI   = 15;
    localparam int          OP_JUMP_LO   = 11;
    localparam int          OP_BSET_LO   = 12;
    localparam int          OFS_HI       = 10;
    localparam int          BIT_HI       = 11;
    localparam int          BIT_LO       = 9;
    localparam int          BANK_FLAG    = 8;
    localparam int          REG_HI       = 7;
    localparam logic [7:0]  ACCESS_SPLIT = 8'h5f;  // 95, low access half
    localparam logic [3:0]  ACCESS_LOW   = 4'h0;
    localparam logic [3:0]  ACCESS_HIGH  = 4'hf;
    localparam logic [15:0] NOP_WORD     = 16'h0000;

    typedef enum logic [3:0] {
        BBSE_Q1 = 4'h1,
        BBSE_Q2 = 4'h2,
        BBSE_Q3 = 4'h4,
        BBSE_Q4 = 4'h8
    } bbse_phase_t;
endpackage

// File: src/bbse_exec.sv
// Purpose: executes relative_jump_op and single_bit_force_op in the core
// Assumes: fetch unit supplies the word and the already advanced pc in Q1
// Notes:   outputs are registered, so each phase action shows one mclk late
//
// Operation
// - jump is 11010, target pc+2+2n
// - offset added to advanced pc, not own
// - jump takes two cycles, second is nop
// - bit force 1000: set bit b, keep rest
// - a=0, no extension: use access bank
// - a=0, extension, f<=5fh: indexed literal offset
`timescale 1ns/1ps
module bbse_exec
    import bbse_pkg::*;
(
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    // fetch side
    input  wire logic [15:0]                   instr,
    input  wire logic [bbse_pkg::PC_W-1:0]     pc_in,
    output logic      [bbse_pkg::PC_W-1:0]     pc_out,
    output logic                               pc_wr,
    output logic                               flush,
    output logic [3:0]                         phase,
    // core controls
    input  wire logic                          ext_en,
    input  wire logic [3:0]                    bank_choice_register,
    input  wire logic [bbse_pkg::ADDR_W-1:0]   index_base,
    // register file side
    output logic [bbse_pkg::ADDR_W-1:0]        reg_addr,
    output logic                               reg_rd,
    output logic                               reg_wr,
    output logic [7:0]                         wr_data,
    input  wire logic [7:0]                    rd_data,
    output logic                               status_wr
);
    import bbse_pkg::*;

    function automatic logic is_jump(input logic [15:0] w);
        return w[OP_JUMP_HI:OP_JUMP_LO] == JUMP_OPCODE;
    endfunction

    function automatic logic is_bset(input logic [15:0] w);
        return w[OP_JUMP_HI:OP_BSET_LO] == BSET_OPCODE;
    endfunction

    function automatic logic [PC_W-1:0] jump_ofs(input logic [15:0] w);
        return {{(PC_W-12){w[OFS_HI]}}, w[OFS_HI:0], 1'b0};
    endfunction

    function automatic logic [ADDR_W-1:0] map_addr(
        input logic [15:0]       w,
        input logic              ext,
        input logic [3:0]        bank,
        input logic [ADDR_W-1:0] base);
        logic [7:0] f;
        f = w[REG_HI:0];
        if (w[BANK_FLAG])
            return {bank, f};
        else if (ext && f <= ACCESS_SPLIT)
            return ADDR_W'(base + {4'h0, f});
        else if (f <= ACCESS_SPLIT)
            return {ACCESS_LOW, f};
        else
            return {ACCESS_HIGH, f};
    endfunction

    ////////////////////////////////////////////////////////////////////
    bbse_phase_t         q;
    bbse_phase_t         next_q;
    logic [15:0]         ir;
    logic [15:0]         next_ir;
    logic [PC_W-1:0]     pc_base;
    logic [PC_W-1:0]     next_pc_base;
    logic                kill;
    logic                next_kill;
    logic [7:0]          rd_hold;
    logic [7:0]          next_rd_hold;
    logic [PC_W-1:0]     next_pc_out;
    logic                next_pc_wr;
    logic                next_flush;
    logic [ADDR_W-1:0]   next_reg_addr;
    logic                next_reg_rd;
    logic                next_reg_wr;
    logic [7:0]          next_wr_data;

    // no arithmetic flag is ever written by these two operations
    assign status_wr = 1'b0;
    assign phase     = q;

    always_comb begin
        next_q        = q;
        next_ir       = ir;
        next_pc_base  = pc_base;
        next_kill     = kill;
        next_rd_hold  = rd_hold;
        next_pc_out   = pc_out;
        next_pc_wr    = 1'b0;
        next_flush    = 1'b0;
        next_reg_addr = reg_addr;
        next_reg_rd   = 1'b0;
        next_reg_wr   = 1'b0;
        next_wr_data  = wr_data;
        unique case (q)
            BBSE_Q1: begin
                next_q       = BBSE_Q2;
                // discarded prefetch runs as a nop word
                next_ir      = kill ? NOP_WORD : instr;
                next_kill    = 1'b0;
                next_pc_base = pc_in;
                if (!kill && is_bset(instr)) begin
                    next_reg_addr = map_addr(instr, ext_en,
                                    bank_choice_register, index_base);
                    next_reg_rd   = 1'b1;
                end
            end
            BBSE_Q2: begin
                next_q       = BBSE_Q3;
                next_rd_hold = rd_data;
            end
            BBSE_Q3: begin
                next_q = BBSE_Q4;
                if (is_jump(ir)) begin
                    next_pc_out = PC_W'(pc_base + jump_ofs(ir));
                    next_pc_wr  = 1'b1;
                    next_flush  = 1'b1;
                    next_kill   = 1'b1;
                end else if (is_bset(ir)) begin
                    next_wr_data = rd_hold | (8'h01 << ir[BIT_HI:BIT_LO]);
                    next_reg_wr  = 1'b1;
                end
            end
            BBSE_Q4: next_q = BBSE_Q1;
            default: next_q = BBSE_Q1;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q        <= BBSE_Q1;
            ir       <= 16'h0000;
            pc_base  <= '0;
            kill     <= 1'b0;
            rd_hold  <= 8'h00;
            pc_out   <= '0;
            pc_wr    <= 1'b0;
            flush    <= 1'b0;
            reg_addr <= '0;
            reg_rd   <= 1'b0;
            reg_wr   <= 1'b0;
            wr_data  <= 8'h00;
        end else begin
            q        <= next_q;
            ir       <= next_ir;
            pc_base  <= next_pc_base;
            kill     <= next_kill;
            rd_hold  <= next_rd_hold;
            pc_out   <= next_pc_out;
            pc_wr    <= next_pc_wr;
            flush    <= next_flush;
            reg_addr <= next_reg_addr;
            reg_rd   <= next_reg_rd;
            reg_wr   <= next_reg_wr;
            wr_data  <= next_wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // target rebuilt from the sampled pc, not from the stored base
    jump_target_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        pc_wr |-> pc_out == PC_W'($past(pc_in, 3)
                  + {{(PC_W-12){ir[OFS_HI]}}, ir[OFS_HI:0], 1'b0}))
        else $error("jump target wrong");

    jump_base_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        pc_wr |-> pc_base == $past(pc_in, 3))
        else $error("jump not based on advanced pc");

    jump_nop_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        pc_wr |-> flush ##1 (!pc_wr && !reg_wr && !reg_rd) [*4])
        else $error("second jump cycle not a nop");

    jump_slot_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        pc_wr |-> phase == 4'h8 && ir[OP_JUMP_HI:OP_JUMP_LO] == JUMP_OPCODE)
        else $error("jump write outside its slot");

    // first edge after reset still shows q1, so skip it
    phase_turn_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        $past(nrst) |-> phase == {$past(phase[2:0]), $past(phase[3])})
        else $error("quarter phase out of turn");

    bit_value_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        reg_wr |-> wr_data == ($past(rd_data, 2)
                              | (8'h01 << ir[BIT_HI:BIT_LO])))
        else $error("bit force value wrong");

    read_write_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        reg_rd |-> ##2 reg_wr && reg_addr == $past(reg_addr, 2))
        else $error("write does not follow read");

    force_slot_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        reg_rd |-> (phase == 4'h2) ##2 (reg_wr && phase == 4'h8))
        else $error("bit force outside its slot");

    access_bank_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        reg_rd && !ir[BANK_FLAG] && !$past(ext_en) |->
        reg_addr == {(ir[REG_HI:0] <= ACCESS_SPLIT) ? ACCESS_LOW
                     : ACCESS_HIGH, ir[REG_HI:0]})
        else $error("access bank address wrong");

    indexed_mode_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        reg_rd && !ir[BANK_FLAG] && $past(ext_en)
        && ir[REG_HI:0] <= ACCESS_SPLIT |->
        reg_addr == ADDR_W'($past(index_base) + {4'h0, ir[REG_HI:0]}))
        else $error("indexed address wrong");

    banked_a: assert property (
        @(posedge mclk) disable iff (!nrst)
        reg_rd && ir[BANK_FLAG] |->
        reg_addr == {$past(bank_choice_register), ir[REG_HI:0]})
        else $error("banked address wrong");
endmodule

// File: tb/bbse_regfile_model.sv
// Purpose: register file on the far side of the executor
// Assumes: read data is wanted within the read cycle
// Notes:   an idle read bus shows inverted data, never the held byte
`timescale 1ns/1ps
module bbse_regfile_model
    import bbse_pkg::*;
(
    // clock
    input  wire logic                        mclk,
    // access
    input  wire logic [bbse_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                        reg_rd,
    input  wire logic                        reg_wr,
    input  wire logic [7:0]                  wr_data,
    output logic      [7:0]                  rd_data
);
    logic [7:0] mem [4096];
    ////////////////////////////////////////////////////////////////////////
    // a stale sample outside the read cycle gets wrong data
    assign rd_data = reg_rd ? mem[reg_addr] : ~mem[reg_addr];
    always @(posedge mclk) begin
        if (reg_wr) begin
            mem[reg_addr] <= wr_data;
        end
    end
endmodule

// File: tb/test_branch_and_bit_set_exec.sv
// Purpose: self-checking bench for the executor
// Assumes: inputs change at falling edges only
// Notes:   the register file model holds the data
`timescale 1ns/1ps
module test_branch_and_bit_set_exec;
    import bbse_pkg::*;
    logic              mclk = 0;
    logic              nrst = 0;
    logic              ext_en = 0;
    logic [3:0]        bank = 4'h0;
    logic [ADDR_W-1:0] base = '0;
    logic [15:0]       instr = NOP_WORD;
    logic [PC_W-1:0]   pc_in = '0;
    logic [PC_W-1:0]   pc_out;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0]        wr_data;
    logic [7:0]        rd_data;
    logic [3:0]        phase;
    logic              pc_wr, flush, reg_rd, reg_wr, status_wr;
    int                errors = 0;
    int                comparisons = 0;
    int                np, nr, nw, ns;
    logic [7:0]        fa;
    bbse_exec dut (.mclk(mclk), .nrst(nrst), .instr(instr), .pc_in(pc_in),
        .pc_out(pc_out), .pc_wr(pc_wr), .flush(flush), .phase(phase),
        .ext_en(ext_en), .bank_choice_register(bank), .index_base(base),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .wr_data(wr_data), .rd_data(rd_data), .status_wr(status_wr));
    bbse_regfile_model model (.mclk(mclk), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .wr_data(wr_data),
        .rd_data(rd_data));
    always #20 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // pulse counts of one slot; status must never be written
    task automatic check_pulses(input int p, input int r, input int w);
        comparisons++;
        if (np != p || nr != r || nw != w || ns != 0) begin
            errors++;
            $display("BAD %0t pulses %0d %0d %0d %0d", $time, np, nr, nw, ns);
        end
    endtask
    task automatic wrap_up();
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one instruction slot; pulses counted over its four quarters
    task automatic run(input logic [15:0] w, input logic [PC_W-1:0] pc);
        np = 0; nr = 0; nw = 0; ns = 0;
        instr = w;
        pc_in = pc;
        repeat (4) begin
            @(negedge mclk);
            instr = NOP_WORD;
            np += (pc_wr === 1'b1 && flush === 1'b1 && phase === 4'h8);
            nr += (reg_rd === 1'b1 && phase === 4'h2);
            nw += (reg_wr === 1'b1 && phase === 4'h8);
            ns += (status_wr !== 1'b0);
        end
        check(phase, 4'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_bset(input int b, input logic a, input logic [7:0] f,
        input logic ext, input logic [ADDR_W-1:0] exp_a);
        logic [7:0] pre;
        pre = 8'h5a & ~(8'h01 << b);
        model.mem[exp_a] = pre;
        ext_en = ext;
        run({BSET_OPCODE, 3'(b), a, f}, '0);
        check_pulses(0, 1, 1);
        check(reg_addr, exp_a);
        check(model.mem[exp_a], pre | (8'h01 << b));
    endtask
    task automatic t_jump(input logic [10:0] n, input logic [PC_W-1:0] pc);
        logic [PC_W-1:0] d;
        d = {{(PC_W - 11){n[10]}}, n};
        // access bank, so a leak would hit the byte checked below
        ext_en = 1'b0;
        run({JUMP_OPCODE, n}, pc);
        check_pulses(1, 0, 0);
        check(pc_out, PC_W'(pc + (d << 1)));
        // slot after the jump is the discarded prefetch
        model.mem[12'h005] = 8'h00;
        run({BSET_OPCODE, 3'h0, 1'b0, 8'h05}, '0);
        check_pulses(0, 0, 0);
        check(model.mem[12'h005], 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        errors++;
        wrap_up();
    end
    initial begin
        repeat (16) @(negedge mclk);
        nrst = 1;
        bank = 4'h3;
        base = 12'hff0;
        for (int b = 0; b < 8; b++) begin
            fa = 8'h80 + 8'(b);
            t_bset(b, 1'b1, fa, 1'b1, {4'h3, fa});
        end
        t_bset(3, 1'b0, 8'h5f, 1'b0, 12'h05f);
        t_bset(6, 1'b0, 8'h60, 1'b0, 12'hf60);
        t_bset(2, 1'b0, 8'h5f, 1'b1, 12'h04f);
        t_bset(5, 1'b0, 8'h60, 1'b1, 12'hf60);
        t_jump(11'h400, 21'h001000);
        t_jump(11'h3ff, 21'h1ffffe);
        run(16'hd800, 21'h000100);
        check_pulses(0, 0, 0);
        t_bset(7, 1'b1, 8'h0a, 1'b0, 12'h30a);
        wrap_up();
    end
endmodule
